// File: design/wdpd_pkg.sv
// Package of constants for the watchdog and power-down control block
package wdpd_pkg;
  // Register byte offsets on the AXI4-Lite bus
  localparam logic [3:0] OFF_TCTL    = 4'h0;
  localparam logic [3:0] OFF_STATUS  = 4'h4;
  localparam logic [3:0] OFF_CMD     = 4'h8;
  // Control register fields
  localparam int         BIT_HALT_WD = 7;
  localparam int         BIT_PSEL_LO = 4;
  localparam int         BIT_STOP_DIS = 3;
  localparam logic [7:0] TCTL_RST    = 8'hf8;
  localparam logic [7:0] UPPER_MASK  = 8'hf8;
  // Status register fields
  localparam int         BIT_STOP_FLAG = 0;
  localparam int         BIT_HALTED    = 1;
  localparam int         BIT_STOPPED   = 2;
  localparam int         BIT_FIRST     = 3;
  // Command register fields
  localparam int         BIT_REFRESH   = 0;
  localparam int         BIT_FLAG_CLR  = 1;
  // Opcodes
  localparam logic [7:0] OP_HALT     = 8'h7f;
  localparam logic [7:0] OP_STOP     = 8'h6f;
  localparam logic [15:0] RESET_ADDR = 16'h0020;
  // Shortest watchdog period is 2**16 crystal clocks
  localparam int         WD_BASE_LOG2 = 16;
  localparam int         WD_CNT_W     = 23;
  // Reset cause encoding
  localparam logic [1:0] CAUSE_PIN   = 2'h0;
  localparam logic [1:0] CAUSE_SMR   = 2'h1;
  localparam logic [1:0] CAUSE_WDT   = 2'h2;
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: design/wdpd_sync.sv
// Two-flop synchroniser for asynchronous inputs
`timescale 1ns/1ps
module wdpd_sync #(
  parameter logic RST_VAL = 1'b1
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Data
  input  wire logic d,
  output logic      q
);
  logic meta_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// File: design/wdpd_wdcnt.sv
// Watchdog down counter with period select
`timescale 1ns/1ps
module wdpd_wdcnt #(
  parameter int BASE_LOG2 = wdpd_pkg::WD_BASE_LOG2,
  parameter int CNT_W     = wdpd_pkg::WD_CNT_W
) (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Control
  input  wire logic [2:0] period_sel,
  input  wire logic       run,
  input  wire logic       restart,
  // Result
  output logic            expired
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             exp;
  } wdpd_cnt_t;
  wdpd_cnt_t s_r, s_nxt;
  logic [CNT_W-1:0] load;

  always_comb begin
    load = CNT_W'(({{(CNT_W-1){1'b0}}, 1'b1} << (BASE_LOG2 + 32'(period_sel) - 1)) - 1'b1);
    s_nxt = s_r;
    s_nxt.exp = 1'b0;
    if (restart || period_sel == 3'h0) begin
      s_nxt.cnt = load;
    end else if (run) begin
      if (s_r.cnt == '0) begin
        s_nxt.exp = 1'b1;
        s_nxt.cnt = load;
      end else begin
        s_nxt.cnt = s_r.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign expired = s_r.exp;
endmodule

// File: design/wdpd_top.sv
// Watchdog and power-down control with AXI4-Lite registers
//
// Functional notes
// - Upper five control bits writable first instruction only
// - Period select: 000 off, else 2^16..2^22 clocks
// - Period select bits reset to all ones
// - Watchdog counts every crystal clock cycle
// - Bit 7 keeps watchdog active in halt
// - Stop disable set makes stop a no-op
// - Stop disable set out of reset
// - Waking from stop sets stop disable again
// - Halt opcode gates core clock, rest runs
// - Interrupt ends halt, resume after halt
// - Pin or watchdog reset restarts at 0020h
// - Enabled stop opcode stops oscillator and clock
// - Stop ends on pin or recovery, flag set
// - Reading stop flag keeps it; firmware clears
// - Low recovery pin level triggers stop recovery
// - Restart at 0020h after recovery pin rises
// - Recovery wake leaves control registers unchanged except stop disable
// - Halt needs no preceding no-op
//
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module wdpd_top (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // External pins
  input  wire logic        reset_pin_n,
  input  wire logic        port_b_bit_zero,
  // Core instruction interface
  input  wire logic        insn_valid,
  input  wire logic [7:0]  insn_opcode,
  input  wire logic        irq_service,
  // Core control outputs
  output logic             core_clk_en,
  output logic             osc_en,
  output logic             core_reset,
  output logic [15:0]      restart_addr,
  output logic [1:0]       reset_cause,
  output logic             halted,
  output logic             stopped,
  // AXI4-Lite write address
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  typedef enum logic [1:0] {
    ST_RUN  = 2'b00,
    ST_HALT = 2'b01,
    ST_STOP = 2'b10
  } wdpd_mode_t;

  typedef struct packed {
    logic [7:0]  tctl;
    logic        first;
    logic        stop_flag;
    wdpd_mode_t  mode;
    logic        core_rst;
    logic [1:0]  cause;
    logic        rpin_prev;
    logic        aw_got;
    logic [3:0]  aw_addr;
    logic        w_got;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        aw_rdy;
    logic        w_rdy;
    logic        ar_rdy;
  } wdpd_state_t;

  wdpd_state_t s_r, s_nxt;
  logic        rpin_s;
  logic        pb0_s;
  logic        wd_expired;
  logic        wd_run;
  logic        wd_restart;
  logic        wr_fire;
  logic [7:0]  status_b;
  logic        flag_set;
  logic        flag_clr;

  // Pin synchronisers
  wdpd_sync #(.RST_VAL(1'b1)) u_sync_rst (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (reset_pin_n),
    .q       (rpin_s)
  );
  wdpd_sync #(.RST_VAL(1'b1)) u_sync_pb0 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (port_b_bit_zero),
    .q       (pb0_s)
  );

  // Watchdog counter
  assign wd_run = (s_r.mode == ST_RUN) ||
                  (s_r.mode == ST_HALT && s_r.tctl[wdpd_pkg::BIT_HALT_WD]);
  assign wr_fire = s_r.aw_got && s_r.w_got && !s_r.bvalid;
  assign wd_restart = s_r.core_rst ||
                      (wr_fire && s_r.aw_addr == wdpd_pkg::OFF_CMD &&
                       s_r.w_strb[0] && s_r.w_data[wdpd_pkg::BIT_REFRESH]);
  wdpd_wdcnt #(
    .BASE_LOG2 (wdpd_pkg::WD_BASE_LOG2),
    .CNT_W     (wdpd_pkg::WD_CNT_W)
  ) u_wdcnt (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .period_sel (s_r.tctl[6:4]),
    .run        (wd_run),
    .restart    (wd_restart),
    .expired    (wd_expired)
  );

  assign status_b = {4'h0, s_r.first, (s_r.mode == ST_STOP), (s_r.mode == ST_HALT), s_r.stop_flag};

  // Stop flag events; a set in the same cycle as a clear wins
  assign flag_set = (s_r.mode == ST_STOP) && (!pb0_s || !rpin_s);
  assign flag_clr = wr_fire && s_r.aw_addr == wdpd_pkg::OFF_CMD &&
                    s_r.w_strb[0] && s_r.w_data[wdpd_pkg::BIT_FLAG_CLR];

  always_comb begin
    logic [7:0] wmask;
    wmask = 8'h00;
    s_nxt = s_r;
    s_nxt.rpin_prev = rpin_s;
    s_nxt.core_rst = 1'b0;

    // Instruction execution
    if (insn_valid && s_r.mode == ST_RUN && !s_r.core_rst) begin
      s_nxt.first = 1'b0;
      if (insn_opcode == wdpd_pkg::OP_HALT) begin
        s_nxt.mode = ST_HALT;
      end else if (insn_opcode == wdpd_pkg::OP_STOP && !s_r.tctl[wdpd_pkg::BIT_STOP_DIS]) begin
        s_nxt.mode = ST_STOP;
      end
    end

    case (s_r.mode)
      ST_HALT: begin
        if (irq_service) begin
          s_nxt.mode = ST_RUN;
        end
      end
      ST_STOP: begin
        if (!pb0_s) begin
          s_nxt.stop_flag = 1'b1;
        end else if (s_r.stop_flag && !s_r.rpin_prev == 1'b0) begin
          s_nxt.mode = ST_RUN;
          s_nxt.core_rst = 1'b1;
          s_nxt.cause = wdpd_pkg::CAUSE_SMR;
          s_nxt.first = 1'b1;
          s_nxt.tctl[wdpd_pkg::BIT_STOP_DIS] = 1'b1;
        end
      end
      ST_RUN: begin
      end
      default: begin
        s_nxt.mode = ST_RUN;
      end
    endcase

    // Register writes
    if (!s_r.aw_got && s_axi_awvalid) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (!s_r.w_got && s_axi_wvalid) begin
      s_nxt.w_got = 1'b1;
      s_nxt.w_data = s_axi_wdata;
      s_nxt.w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = wdpd_pkg::RESP_OKAY;
      case (s_r.aw_addr)
        wdpd_pkg::OFF_TCTL: begin
          wmask = s_r.first ? wdpd_pkg::UPPER_MASK : 8'h00;
          if (s_r.w_strb[0]) begin
            s_nxt.tctl = (s_r.tctl & ~wmask) | (s_r.w_data[7:0] & wmask);
          end
        end
        wdpd_pkg::OFF_CMD: begin
          if (flag_clr && !flag_set) begin
            s_nxt.stop_flag = 1'b0;
          end
        end
        wdpd_pkg::OFF_STATUS: begin
        end
        default: begin
          s_nxt.bresp = wdpd_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end

    // Register reads
    if (!s_r.rvalid && s_axi_arvalid) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = wdpd_pkg::RESP_OKAY;
      case (s_axi_araddr)
        wdpd_pkg::OFF_TCTL: s_nxt.rdata = {24'h000000, s_r.tctl};
        wdpd_pkg::OFF_STATUS: s_nxt.rdata = {24'h000000, status_b};
        wdpd_pkg::OFF_CMD: s_nxt.rdata = 32'h00000000;
        default: begin
          s_nxt.rdata = 32'h00000000;
          s_nxt.rresp = wdpd_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end

    // Pin and watchdog resets reinitialise control
    if (!rpin_s || (wd_expired && s_r.tctl[6:4] != 3'h0)) begin
      s_nxt.tctl = wdpd_pkg::TCTL_RST;
      s_nxt.first = 1'b1;
      s_nxt.mode = ST_RUN;
      s_nxt.core_rst = 1'b1;
      s_nxt.cause = !rpin_s ? wdpd_pkg::CAUSE_PIN : wdpd_pkg::CAUSE_WDT;
      if (s_r.mode == ST_STOP) begin
        s_nxt.stop_flag = 1'b1;
      end
    end

    // Ready outputs come straight from flops
    s_nxt.aw_rdy = !s_nxt.aw_got;
    s_nxt.w_rdy  = !s_nxt.w_got;
    s_nxt.ar_rdy = !s_nxt.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.tctl <= wdpd_pkg::TCTL_RST;
      s_r.first <= 1'b1;
      s_r.mode <= ST_RUN;
      s_r.rpin_prev <= 1'b1;
      s_r.core_rst <= 1'b1;
      s_r.aw_rdy <= 1'b1;
      s_r.w_rdy <= 1'b1;
      s_r.ar_rdy <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_clk_en  <= 1'b1;
      osc_en       <= 1'b1;
      core_reset   <= 1'b1;
      restart_addr <= wdpd_pkg::RESET_ADDR;
      reset_cause  <= wdpd_pkg::CAUSE_PIN;
      halted       <= 1'b0;
      stopped      <= 1'b0;
    end else begin
      core_clk_en  <= (s_nxt.mode == ST_RUN);
      osc_en       <= (s_nxt.mode != ST_STOP);
      core_reset   <= s_nxt.core_rst;
      restart_addr <= wdpd_pkg::RESET_ADDR;
      reset_cause  <= s_nxt.cause;
      halted       <= (s_nxt.mode == ST_HALT);
      stopped      <= (s_nxt.mode == ST_STOP);
    end
  end

  assign s_axi_awready = s_r.aw_rdy;
  assign s_axi_wready  = s_r.w_rdy;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_arready = s_r.ar_rdy;
  assign s_axi_rvalid  = s_r.rvalid;
  assign s_axi_rdata   = s_r.rdata;
  assign s_axi_rresp   = s_r.rresp;
endmodule

// File: tb/wdpd_top_asserts.sv
// Port assertions for the watchdog and power-down control
`timescale 1ns/1ps
module wdpd_top_asserts (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Pins
  input wire logic        reset_pin_n,
  // Core side
  input wire logic        insn_valid,
  input wire logic [7:0]  insn_opcode,
  input wire logic        irq_service,
  input wire logic        core_clk_en,
  input wire logic        osc_en,
  input wire logic        core_reset,
  input wire logic [15:0] restart_addr,
  input wire logic [1:0]  reset_cause,
  input wire logic        halted,
  input wire logic        stopped
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic go;
  assign go = insn_valid && core_clk_en && !core_reset;
  AST_ADDR: assert property (core_reset |-> restart_addr == 16'h0020)
    else $error("bad restart address");
  AST_HALT: assert property (go && insn_opcode == 8'h7f |=> halted && !core_clk_en)
    else $error("halt not entered");
  AST_HALT_OSC: assert property (halted |-> osc_en && !core_clk_en)
    else $error("bad clocks in halt");
  AST_HALT_HOLD: assert property (halted && !irq_service |=> halted or ##[0:2] core_reset)
    else $error("halt left early");
  AST_WAKE: assert property (halted && irq_service && !core_reset |=> !halted && core_clk_en)
    else $error("halt not left");
  AST_STOP: assert property (stopped |-> !osc_en && !core_clk_en)
    else $error("clocks run in stop");
  AST_STOP_EXIT: assert property ($fell(stopped) |-> $past(core_reset) or ##[0:2] core_reset)
    else $error("stop left without reset");
  AST_PULSE: assert property (core_reset && reset_cause != 2'h0 |=> !core_reset)
    else $error("reset pulse too long");
  AST_PIN_RST: assert property (!reset_pin_n |-> ##[1:4] (core_reset && reset_cause == 2'h0))
    else $error("pin reset not applied");
  AST_RESTART: assert property (core_reset |=> core_clk_en && !halted && !stopped)
    else $error("no restart after reset");
endmodule

bind wdpd_top wdpd_top_asserts chk_u (
  .aclk(aclk), .aresetn(aresetn), .reset_pin_n(reset_pin_n), .insn_valid(insn_valid),
  .insn_opcode(insn_opcode), .irq_service(irq_service), .core_clk_en(core_clk_en), .osc_en(osc_en),
  .core_reset(core_reset), .restart_addr(restart_addr), .reset_cause(reset_cause), .halted(halted),
  .stopped(stopped)
);

// File: tb/wdpd_smr_src.sv
// Stop recovery pin source model
`timescale 1ns/1ps
module wdpd_smr_src (
  // Clock
  input  wire logic       aclk,
  // Request from the bench
  input  wire logic       go,
  input  wire logic [7:0] wid,
  // Recovery pin, idle high
  output logic            rec_pin
);
  logic [7:0] cnt = 8'h00;
  initial rec_pin = 1'b1;
  always @(posedge aclk) begin
    if (go) begin
      rec_pin <= 1'b0;
      cnt <= wid;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end else begin
      rec_pin <= 1'b1;
    end
  end
endmodule

// File: tb/test_watchdog_and_power_down_control.sv
// Bench for the watchdog and power-down control
`timescale 1ns/1ps
module test_watchdog_and_power_down_control;
  logic        aclk = 0, aresetn = 0, reset_pin_n = 1, insn_valid = 0, irq_service = 0, go = 0, rec_pin;
  logic        core_clk_en, osc_en, core_reset, halted, stopped, awready, wready, bvalid, arready, rvalid;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0]  insn_opcode = 8'h00, wid = 8'h04;
  logic [15:0] restart_addr;
  logic [1:0]  reset_cause, bresp, rresp, rsp;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0, md;
  logic [31:0] wdata = 32'h0, rdata, rd, seed = 32'd2597;
  int          n_fail = 0, compares = 0, n;
  assign md = {halted, stopped, core_clk_en, osc_en};
  always #4 aclk = ~aclk;
  wdpd_top dut_u (.aclk(aclk), .aresetn(aresetn), .reset_pin_n(reset_pin_n), .port_b_bit_zero(rec_pin),
    .insn_valid(insn_valid), .insn_opcode(insn_opcode), .irq_service(irq_service), .core_clk_en(core_clk_en),
    .osc_en(osc_en), .core_reset(core_reset), .restart_addr(restart_addr), .reset_cause(reset_cause),
    .halted(halted), .stopped(stopped), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  wdpd_smr_src smr_u (.aclk(aclk), .go(go), .wid(wid), .rec_pin(rec_pin));
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task end_sim();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(string nm, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task bus(bit wr, logic [3:0] a, logic [31:0] d);
    bit ta, tw, tr, dn;
    @(posedge aclk);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= wr;
    wvalid <= wr;
    bready <= wr;
    arvalid <= !wr;
    rready <= !wr;
    dn = 0;
    for (int i = 0; i < 40 && !dn; i++) begin
      @(negedge aclk);
      ta = awready;
      tw = wready;
      tr = arready;
      dn = wr ? bvalid : rvalid;
      rd = rdata;
      rsp = wr ? bresp : rresp;
      @(posedge aclk);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
      if (tr) arvalid <= 0;
    end
    bready <= 0;
    rready <= 0;
    if (!dn) begin
      n_fail++;
      end_sim();
    end
  endtask
  task rdc(string nm, logic [3:0] a, logic [31:0] m, logic [31:0] e);
    bus(0, a, 32'h0);
    chk(nm, e, rd & m);
  endtask
  task ins(logic [7:0] op);
    @(posedge aclk);
    insn_valid <= 1;
    insn_opcode <= op;
    @(posedge aclk);
    insn_valid <= 0;
    @(negedge aclk);
  endtask
  task nop();
    ins(8'(xs()) & 8'h3f);
  endtask
  task wrst(int lim);
    for (n = 0; n < lim; n++) begin
      @(negedge aclk);
      if (core_reset === 1'b1) break;
    end
    if (n == lim) begin
      n_fail++;
      end_sim();
    end
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    rdc("ctl", 4'h0, 32'hff, 32'hf8);
    rdc("stat", 4'h4, 32'h0e, 32'h08);
    bus(0, 4'hc, 32'h0);
    chk("unmapped_data", 32'h0, rd);
    chk("unmapped_resp", 32'h2, 32'(rsp));
    bus(1, 4'h0, 32'h0);
    rdc("ctl_first", 4'h0, 32'hff, 32'h00);
    nop();
    bus(1, 4'h0, 32'hf8);
    rdc("ctl_lock", 4'h0, 32'hff, 32'h00);
    $display("test registers done");
    ins(8'h7f);
    chk("halt", 32'h9, 32'(md));
    nop();
    chk("halt_ignore", 32'h9, 32'(md));
    @(posedge aclk);
    irq_service <= 1;
    @(posedge aclk);
    irq_service <= 0;
    @(negedge aclk);
    chk("halt_wake", 32'h3, 32'(md));
    $display("test halt done");
    ins(8'h6f);
    chk("stop", 32'h4, 32'(md));
    @(posedge aclk);
    go <= 1;
    wid <= 8'h04 + (8'(xs()) & 8'h0f);
    @(posedge aclk);
    go <= 0;
    wrst(80);
    chk("cause_smr", 32'h1, 32'(reset_cause));
    rdc("flag", 4'h4, 32'h1, 32'h1);
    rdc("flag_again", 4'h4, 32'h1, 32'h1);
    rdc("ctl_smr", 4'h0, 32'hff, 32'h08);
    bus(1, 4'h8, 32'h2);
    rdc("flag_clr", 4'h4, 32'h1, 32'h0);
    ins(8'h6f);
    chk("stop_nop", 32'h3, 32'(md));
    $display("test stop done");
    ins(8'h7f);
    fork
      begin
        @(posedge aclk);
        reset_pin_n <= 0;
        repeat (6) @(posedge aclk);
        reset_pin_n <= 1;
      end
      wrst(30);
    join
    repeat (4) @(negedge aclk);
    chk("cause_pin", 32'h0, 32'(reset_cause));
    chk("pin_run", 32'h3, 32'(md));
    rdc("ctl_pin", 4'h0, 32'hff, 32'hf8);
    $display("test pin reset done");
    bus(1, 4'h0, 32'h98);
    bus(1, 4'h8, 32'h1);
    wrst(65536 + 40);
    chk("wd_time", 32'h1, 32'(n >= 65536 - 4 && n <= 65536 + 4));
    chk("cause_wd", 32'h2, 32'(reset_cause));
    rdc("ctl_wd", 4'h0, 32'hff, 32'hf8);
    $display("test watchdog done");
    end_sim();
  end
endmodule
